/* core/pdi_alias_match.v */
// Comparator of one programmable per-port serial target address
`timescale 1ns/1ps
`default_nettype none

module pdi_alias_match (
  // Programmed alias and incoming address
  input wire [6:0] alias_id,
  input wire [6:0] target_addr,
  // Match result
  output wire hit
);

  // A zero alias turns the decoder off
  assign hit = (alias_id != 7'h00) && (alias_id == target_addr);

endmodule // pdi_alias_match

`default_nettype wire

/* core/pdi_consts.vh */
// Offsets, field positions and reset values of the port decode and window block
`ifndef PDI_CONSTS_VH
`define PDI_CONSTS_VH

// Main map offsets
`define PDI_ADDR_PORT_SELECT 8'h4C
`define PDI_ADDR_WIN_CTL 8'hB0
`define PDI_ADDR_WIN_OFF 8'hB1
`define PDI_ADDR_WIN_DATA 8'hB2
`define PDI_ADDR_IDENT_FIVE 8'hF4
`define PDI_ADDR_IDENT_SIX 8'hF5
`define PDI_ADDR_ALIAS0 8'hF8
`define PDI_ADDR_ALIAS1 8'hF9
`define PDI_ADDR_RSVD_FA 8'hFA
`define PDI_ADDR_RSVD_FB 8'hFB

// Window control fields
`define PDI_CTL_SEL_MSB 5
`define PDI_CTL_SEL_LSB 2
`define PDI_CTL_AUTO_INC 1

// Block select codes
`define PDI_SEL_PAGE0 4'h0
`define PDI_SEL_CHAN0 4'h1
`define PDI_SEL_CHAN1 4'h2
`define PDI_SEL_SHARE 4'h5
`define PDI_SEL_ALL_CHAN 4'h6
`define PDI_SEL_CSI_TEST 4'h7

// Indirect page offsets and range ends
`define PDI_PG_CTL 8'h01
`define PDI_PG_CFG 8'h02
`define PDI_PG_DI 8'h03
`define PDI_PG_LEN_HI 8'h04
`define PDI_PG_LEN_LO 8'h05
`define PDI_PG_MEM_FIRST 8'h06
`define PDI_PG_MEM_LAST 8'h1F
`define PDI_CSI_TIM_FIRST 8'h40
`define PDI_CSI_TIM_LAST 8'h48
`define PDI_CHAN_LAST 8'h14
`define PDI_SHARE_LAST 8'h04
`define PDI_CSI_TEST_LAST 8'h1D

// Reset values
`define PDI_RST_PORT_SELECT 8'h01
`define PDI_RST_PG_CTL 8'h00
`define PDI_RST_PG_CFG 8'h33
`define PDI_RST_PG_DI 8'h24
`define PDI_RST_LINE_LEN 16'h0780
`define PDI_RST_LEN_HI 8'h07
`define PDI_RST_LEN_LO 8'h80

`endif

/* core/pdi_port_decode_indirect.v */
// Serial target, alias decoders, indirect window and pattern settings
`timescale 1ns/1ps
`default_nettype none
`include "pdi_consts.vh"

module pdi_port_decode_indirect #(
  parameter [6:0] MAIN_ADDR = 7'h30,
  // Arbitrary identity values
  parameter [7:0] IDENT_FIVE = 8'h41,
  parameter [7:0] IDENT_SIX = 8'h42
) (
  // Clock and reset
  input wire ref_clk,
  input wire rstn,
  // Serial control pins
  input wire scl_pin,
  input wire sda_in,
  output wire sda_out,
  output reg sda_drive_n,
  // Port specific register space
  output wire ext_wr_stb,
  output wire ext_rd_stb,
  output wire [7:0] ext_addr,
  output wire [7:0] ext_wdata,
  input wire [7:0] ext_rdata,
  output wire [1:0] ext_port_mask,
  // Pattern generator settings
  output wire pattern_run,
  output wire fixed_color_select,
  output wire [1:0] bar_count,
  output wire [3:0] block_size,
  output wire [1:0] pattern_virtual_channel,
  output wire [5:0] pattern_data_type,
  output wire [15:0] pattern_line_length
);

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_ADDR = 3'd1;
  localparam [2:0] ST_ADDR_ACK = 3'd2;
  localparam [2:0] ST_WRITE = 3'd3;
  localparam [2:0] ST_WRITE_ACK = 3'd4;
  localparam [2:0] ST_READ = 3'd5;
  localparam [2:0] ST_READ_ACK = 3'd6;

  ////////////////////////////////////////////////////////////////////////////
  // Decode functions

  // Registers held in this block rather than in the port space
  function is_local;
    input [7:0] a;
    begin
      case (a)
        `PDI_ADDR_PORT_SELECT, `PDI_ADDR_WIN_CTL, `PDI_ADDR_WIN_OFF,
        `PDI_ADDR_WIN_DATA, `PDI_ADDR_IDENT_FIVE, `PDI_ADDR_IDENT_SIX,
        `PDI_ADDR_ALIAS0, `PDI_ADDR_ALIAS1, `PDI_ADDR_RSVD_FA,
        `PDI_ADDR_RSVD_FB: is_local = 1'b1;
        default: is_local = 1'b0;
      endcase
    end
  endfunction

  // Offsets that exist inside the selected block
  function win_in_range;
    input [3:0] sel;
    input [7:0] off;
    begin
      case (sel)
        `PDI_SEL_PAGE0: win_in_range = ((off >= `PDI_PG_CTL) && (off <= `PDI_PG_MEM_LAST)) ||
          ((off >= `PDI_CSI_TIM_FIRST) && (off <= `PDI_CSI_TIM_LAST));
        `PDI_SEL_CHAN0, `PDI_SEL_CHAN1, `PDI_SEL_ALL_CHAN:
          win_in_range = (off <= `PDI_CHAN_LAST);
        `PDI_SEL_SHARE: win_in_range = (off <= `PDI_SHARE_LAST);
        `PDI_SEL_CSI_TEST: win_in_range = (off <= `PDI_CSI_TEST_LAST);
        default: win_in_range = 1'b0;
      endcase
    end
  endfunction

  // Page 0 offsets kept in flip-flops
  function is_pattern_reg;
    input [3:0] sel;
    input [7:0] off;
    begin
      is_pattern_reg = (sel == `PDI_SEL_PAGE0) && (off >= `PDI_PG_CTL) &&
        (off <= `PDI_PG_LEN_LO);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus events

  reg [2:0] scl_sync;
  reg [2:0] sda_sync;

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      scl_sync <= 3'b111;
      sda_sync <= 3'b111;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_pin};
      sda_sync <= {sda_sync[1:0], sda_in};
    end
  end

  wire scl_rise = scl_sync[1] & ~scl_sync[2];
  wire scl_fall = ~scl_sync[1] & scl_sync[2];
  wire bus_start = scl_sync[1] & scl_sync[2] & sda_sync[2] & ~sda_sync[1];
  wire bus_stop = scl_sync[1] & scl_sync[2] & ~sda_sync[2] & sda_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  reg [2:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg rw_read;
  reg first_byte;
  reg master_ack;
  reg [7:0] reg_ptr;
  reg [1:0] hit_port;
  reg [7:0] port_select;
  reg [5:0] win_ctl;
  reg [7:0] win_off;
  reg [6:0] alias_id [0:1];
  reg [7:0] pg_ctl;
  reg [7:0] pg_cfg;
  reg [7:0] pg_di;
  reg [7:0] len_hi;
  reg [7:0] len_lo;

  wire [3:0] win_sel = win_ctl[`PDI_CTL_SEL_MSB:`PDI_CTL_SEL_LSB];
  wire win_auto = win_ctl[`PDI_CTL_AUTO_INC];
  wire win_valid = win_in_range(win_sel, win_off);
  wire win_flop = is_pattern_reg(win_sel, win_off);

  ////////////////////////////////////////////////////////////////////////////
  // Alias decoders

  wire [1:0] alias_hit;
  wire main_hit = (shift[7:1] == MAIN_ADDR);

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_alias
      pdi_alias_match u_match (
        .alias_id(alias_id[gi]),
        .target_addr(shift[7:1]),
        .hit(alias_hit[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Access pulses

  wire end_of_byte = scl_fall && (bit_cnt == 4'd8);
  wire wr_pulse = end_of_byte && (state == ST_WRITE) && !first_byte;
  wire ptr_pulse = end_of_byte && (state == ST_WRITE) && first_byte;
  wire rd_pulse = scl_fall && (((state == ST_ADDR_ACK) && rw_read) ||
    ((state == ST_READ_ACK) && master_ack));
  wire data_access = (wr_pulse || rd_pulse) && (reg_ptr == `PDI_ADDR_WIN_DATA);

  assign ext_wr_stb = wr_pulse && !is_local(reg_ptr);
  assign ext_rd_stb = rd_pulse && !is_local(reg_ptr);
  assign ext_addr = reg_ptr;
  assign ext_wdata = shift;
  // Alias transactions pin the port, otherwise the select register does
  assign ext_port_mask = (hit_port != 2'b00) ? hit_port : port_select[1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Window store

  wire [9:0] win_mem_addr = (win_sel == `PDI_SEL_ALL_CHAN) ?
    {3'd1, win_off[6:0]} : {win_sel[2:0], win_off[6:0]};
  wire mem_wr = wr_pulse && (reg_ptr == `PDI_ADDR_WIN_DATA) && win_valid && !win_flop;
  wire [7:0] mem_rdata;

  pdi_window_mem u_mem (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .wr_a_en(mem_wr),
    .wr_a_addr(win_mem_addr),
    .wr_b_en(mem_wr && (win_sel == `PDI_SEL_ALL_CHAN)),
    .wr_b_addr({3'd2, win_off[6:0]}),
    .wr_data(shift),
    .rd_addr(win_mem_addr),
    .rd_data(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read data selection

  reg [7:0] win_rdata;
  reg [7:0] rd_byte;

  always @* begin
    win_rdata = 8'h00;
    if (win_flop) begin
      case (win_off)
        `PDI_PG_CTL: win_rdata = pg_ctl;
        `PDI_PG_CFG: win_rdata = pg_cfg;
        `PDI_PG_DI: win_rdata = pg_di;
        `PDI_PG_LEN_HI: win_rdata = len_hi;
        default: win_rdata = len_lo;
      endcase
    end else if (win_valid) begin
      win_rdata = mem_rdata;
    end
  end

  always @* begin
    case (reg_ptr)
      `PDI_ADDR_PORT_SELECT: rd_byte = port_select;
      `PDI_ADDR_WIN_CTL: rd_byte = {2'b00, win_ctl};
      `PDI_ADDR_WIN_OFF: rd_byte = win_off;
      `PDI_ADDR_WIN_DATA: rd_byte = win_rdata;
      `PDI_ADDR_IDENT_FIVE: rd_byte = IDENT_FIVE;
      `PDI_ADDR_IDENT_SIX: rd_byte = IDENT_SIX;
      `PDI_ADDR_ALIAS0: rd_byte = {alias_id[0], 1'b0};
      `PDI_ADDR_ALIAS1: rd_byte = {alias_id[1], 1'b0};
      `PDI_ADDR_RSVD_FA, `PDI_ADDR_RSVD_FB: rd_byte = 8'h00;
      default: rd_byte = ext_rdata;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial target state machine

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      rw_read <= 1'b0;
      first_byte <= 1'b0;
      master_ack <= 1'b0;
      hit_port <= 2'b00;
      sda_drive_n <= 1'b1;
    end else if (bus_start) begin
      state <= ST_ADDR;
      bit_cnt <= 4'h0;
      sda_drive_n <= 1'b1;
    end else if (bus_stop) begin
      state <= ST_IDLE;
      sda_drive_n <= 1'b1;
    end else begin
      case (state)
        ST_ADDR: begin
          if (scl_rise) begin
            shift <= {shift[6:0], sda_sync[1]};
            bit_cnt <= bit_cnt + 4'd1;
          end else if (end_of_byte) begin
            if (main_hit || (alias_hit != 2'b00)) begin
              state <= ST_ADDR_ACK;
              sda_drive_n <= 1'b0;
              rw_read <= shift[0];
              hit_port <= main_hit ? 2'b00 : alias_hit;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_read) begin
              state <= ST_READ;
              shift <= rd_byte;
              sda_drive_n <= rd_byte[7];
              bit_cnt <= 4'd1;
            end else begin
              state <= ST_WRITE;
              sda_drive_n <= 1'b1;
              bit_cnt <= 4'h0;
              first_byte <= 1'b1;
            end
          end
        end
        ST_WRITE: begin
          if (scl_rise) begin
            shift <= {shift[6:0], sda_sync[1]};
            bit_cnt <= bit_cnt + 4'd1;
          end else if (end_of_byte) begin
            state <= ST_WRITE_ACK;
            sda_drive_n <= 1'b0;
            first_byte <= 1'b0;
          end
        end
        ST_WRITE_ACK: begin
          if (scl_fall) begin
            state <= ST_WRITE;
            sda_drive_n <= 1'b1;
            bit_cnt <= 4'h0;
          end
        end
        ST_READ: begin
          if (end_of_byte) begin
            state <= ST_READ_ACK;
            sda_drive_n <= 1'b1;
          end else if (scl_fall) begin
            shift <= {shift[6:0], 1'b0};
            sda_drive_n <= shift[6];
            bit_cnt <= bit_cnt + 4'd1;
          end
        end
        ST_READ_ACK: begin
          if (scl_rise) begin
            master_ack <= ~sda_sync[1];
          end else if (scl_fall) begin
            if (master_ack) begin
              state <= ST_READ;
              shift <= rd_byte;
              sda_drive_n <= rd_byte[7];
              bit_cnt <= 4'd1;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          sda_drive_n <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bank

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_ptr <= 8'h00;
      port_select <= `PDI_RST_PORT_SELECT;
      win_ctl <= 6'h00;
      win_off <= 8'h00;
      alias_id[0] <= 7'h00;
      alias_id[1] <= 7'h00;
      pg_ctl <= `PDI_RST_PG_CTL;
      pg_cfg <= `PDI_RST_PG_CFG;
      pg_di <= `PDI_RST_PG_DI;
      len_hi <= `PDI_RST_LEN_HI;
      len_lo <= `PDI_RST_LEN_LO;
    end else begin
      if (ptr_pulse) begin
        reg_ptr <= shift;
      end else if (wr_pulse || rd_pulse) begin
        reg_ptr <= reg_ptr + 8'd1;
      end
      if (wr_pulse) begin
        case (reg_ptr)
          `PDI_ADDR_PORT_SELECT: port_select <= shift;
          `PDI_ADDR_WIN_CTL: win_ctl <= shift[5:0];
          `PDI_ADDR_WIN_OFF: win_off <= shift;
          `PDI_ADDR_ALIAS0: alias_id[0] <= shift[7:1];
          `PDI_ADDR_ALIAS1: alias_id[1] <= shift[7:1];
          default: begin
          end
        endcase
      end
      if (wr_pulse && (reg_ptr == `PDI_ADDR_WIN_DATA) && win_flop) begin
        case (win_off)
          `PDI_PG_CTL: pg_ctl <= shift;
          `PDI_PG_CFG: pg_cfg <= shift;
          `PDI_PG_DI: pg_di <= shift;
          `PDI_PG_LEN_HI: len_hi <= shift;
          default: len_lo <= shift;
        endcase
      end
      // A data access moves the offset on only in auto-increment mode
      if (data_access && win_auto) begin
        win_off <= win_off + 8'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pattern generator outputs

  assign pattern_run = pg_ctl[0];
  assign fixed_color_select = pg_cfg[7];
  assign bar_count = pg_cfg[5:4];
  // Zero is outside the allowed sizes and is passed on as written
  assign block_size = pg_cfg[3:0];
  assign pattern_virtual_channel = pg_di[7:6];
  assign pattern_data_type = pg_di[5:0];
  assign pattern_line_length = {len_hi, len_lo};
  assign sda_out = 1'b0;

endmodule // pdi_port_decode_indirect

`default_nettype wire

/* core/pdi_window_mem.v */
// Byte store behind the indirect window, two write ports and registered read
`timescale 1ns/1ps
`default_nettype none

module pdi_window_mem (
  // Clock and reset
  input wire ref_clk,
  input wire rstn,
  // Write ports sharing one data byte
  input wire wr_a_en,
  input wire [9:0] wr_a_addr,
  input wire wr_b_en,
  input wire [9:0] wr_b_addr,
  input wire [7:0] wr_data,
  // Read port
  input wire [9:0] rd_addr,
  output reg [7:0] rd_data
);

  reg [7:0] store [0:1023];

  always @(posedge ref_clk) begin
    if (wr_a_en) begin
      store[wr_a_addr] <= wr_data;
    end
    if (wr_b_en) begin
      store[wr_b_addr] <= wr_data;
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= store[rd_addr];
    end
  end

endmodule // pdi_window_mem

`default_nettype wire

/* tb/pdi_chk_sva.sv */
// Checker of the port decode and window block
`timescale 1ns/1ps
`default_nettype none
module pdi_chk (
  // Clock, reset and serial pins
  input wire ref_clk,
  input wire rstn,
  input wire scl_pin,
  input wire sda_out,
  input wire sda_drive_n,
  // Port space strobes
  input wire ext_wr_stb,
  input wire ext_rd_stb,
  // Pattern settings
  input wire pattern_run,
  input wire fixed_color_select,
  input wire [1:0] bar_count,
  input wire [3:0] block_size,
  input wire [1:0] pattern_virtual_channel,
  input wire [5:0] pattern_data_type,
  input wire [15:0] pattern_line_length
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire [31:0] cfg = {pattern_run, fixed_color_select, bar_count, block_size,
    pattern_virtual_channel, pattern_data_type, pattern_line_length};
  sequence s_wr_pulse;
    ext_wr_stb ##1 !ext_wr_stb [*8];
  endsequence
  sequence s_rd_pulse;
    ext_rd_stb ##1 !ext_rd_stb [*8];
  endsequence
  a_reset_values: assert property ($rose(rstn) |-> cfg == 32'h3324_0780)
    else $error("settings differ from reset values");
  a_wr_once: assert property (ext_wr_stb |-> s_wr_pulse)
    else $error("write strobe repeated");
  a_rd_once: assert property (ext_rd_stb |-> s_rd_pulse)
    else $error("read strobe repeated");
  a_stb_excl: assert property (!(ext_wr_stb && ext_rd_stb))
    else $error("both strobes high");
  a_stb_scl_low: assert property (ext_wr_stb || ext_rd_stb |-> !scl_pin)
    else $error("strobe while clock high");
  a_cfg_scl_low: assert property (!$stable(cfg) |-> !scl_pin)
    else $error("settings moved while clock high");
  a_drive_scl_low: assert property ($changed(sda_drive_n) |-> !scl_pin)
    else $error("data drive moved while clock high");
  a_drive_bounded: assert property ($fell(sda_drive_n) |-> ##[1:300] sda_drive_n)
    else $error("data held low too long");
  a_sda_zero: assert property (sda_out == 1'b0)
    else $error("drive value not low");
endmodule // pdi_chk
bind pdi_port_decode_indirect pdi_chk u_pdi_chk (.ref_clk, .rstn, .scl_pin, .sda_out,
  .sda_drive_n, .ext_wr_stb, .ext_rd_stb, .pattern_run, .fixed_color_select, .bar_count,
  .block_size, .pattern_virtual_channel, .pattern_data_type, .pattern_line_length);
`default_nettype wire

/* tb/pdi_host.sv */
// Serial host model driving the clock and open drain data line
`timescale 1ns/1ps
`default_nettype none
module pdi_host (
  // Clock and resolved data line
  input wire ref_clk,
  input wire sda_line,
  // Host drive, data pulled low when set
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Five cycles a phase keeps every phase above the receiver minimum
  task automatic half();
    repeat (5) @(negedge ref_clk);
  endtask
  // Also makes a repeated start from a low clock
  task automatic start();
    sda_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
    half();
  endtask
  task automatic stop();
    sda_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask
  // Sends d then a_in; q and a_out return what the line held
  task automatic xfer(input logic [7:0] d, input logic a_in, output logic [7:0] q,
    output logic a_out);
    for (int i = 8; i >= 0; i--) begin
      sda_low = (i > 0) ? !d[i-1] : !a_in;
      half();
      scl = 1'b1;
      half();
      if (i > 0) q[i-1] = sda_line;
      else a_out = sda_line;
      scl = 1'b0;
      half();
    end
  endtask
endmodule // pdi_host
`default_nettype wire

/* tb/tb.sv */
// Bench of the port decode and window block
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [6:0] MAIN = 7'h30;
  // Arbitrary identity values
  localparam logic [7:0] ID5 = 8'h61;
  localparam logic [7:0] ID6 = 8'h62;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  logic ack;
  logic [7:0] rb [4];
  logic [17:0] seen;
  logic [39:0] rst_pg = 40'h00_3324_0780;
  // Block select, offset, byte written, byte read back
  logic [27:0] rows [20] = '{28'h001_8181, 28'h002_A5A5, 28'h003_5E5E, 28'h004_1212,
    28'h005_3434, 28'h000_FF00, 28'h01F_A5A5, 28'h020_1100, 28'h048_6666, 28'h049_6600,
    28'h114_7777, 28'h115_7700, 28'h205_5A5A, 28'h300_5500, 28'h400_5500, 28'h504_9999,
    28'h505_9900, 28'h610_C3C3, 28'h71D_3C3C, 28'h71E_3C00};
  wire scl_pin, host_low, sda_out, sda_drive_n, ext_wr_stb, ext_rd_stb;
  wire pattern_run, fixed_color_select;
  wire [7:0] ext_addr, ext_wdata;
  wire [1:0] ext_port_mask, bar_count, pattern_virtual_channel;
  wire [3:0] block_size;
  wire [5:0] pattern_data_type;
  wire [15:0] pattern_line_length;
  // Pulled-up data line
  wire sda_in = !(host_low || (!sda_drive_n && !sda_out));
  wire [7:0] ext_rdata = ext_rd_stb ? ext_addr ^ 8'h5A : 8'hA5;
  wire [31:0] cfg = {pattern_run, fixed_color_select, bar_count, block_size,
    pattern_virtual_channel, pattern_data_type, pattern_line_length};
  initial begin
    forever #12.5 ref_clk = !ref_clk;
  end
  pdi_port_decode_indirect #(.MAIN_ADDR(MAIN), .IDENT_FIVE(ID5), .IDENT_SIX(ID6))
    u_pdi_port_decode_indirect (.ref_clk, .rstn, .scl_pin, .sda_in, .sda_out, .sda_drive_n,
    .ext_wr_stb, .ext_rd_stb, .ext_addr, .ext_wdata, .ext_rdata, .ext_port_mask, .pattern_run,
    .fixed_color_select, .bar_count, .block_size, .pattern_virtual_channel, .pattern_data_type,
    .pattern_line_length);
  pdi_host u_pdi_host (.ref_clk, .sda_line(sda_in), .scl(scl_pin), .sda_low(host_low));
  always @(posedge ref_clk) begin
    if (ext_wr_stb) seen <= {ext_port_mask, ext_addr, ext_wdata};
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Pointer, nw data bytes, then a repeated start and nr reads
  task automatic seq(input logic [6:0] a, input logic [7:0] p, input logic [23:0] w,
    input int nw, input int nr);
    logic [7:0] q;
    logic k;
    u_pdi_host.start();
    u_pdi_host.xfer({a, 1'b0}, 1'b1, q, ack);
    if (ack === 1'b0) begin
      u_pdi_host.xfer(p, 1'b1, q, k);
      for (int i = 0; i < nw; i++) u_pdi_host.xfer(w[23-8*i -: 8], 1'b1, q, k);
      if (nr > 0) begin
        u_pdi_host.start();
        u_pdi_host.xfer({a, 1'b1}, 1'b1, q, k);
        for (int i = 0; i < nr; i++) u_pdi_host.xfer(8'hFF, i == nr - 1, rb[i], k);
      end
    end
    u_pdi_host.stop();
  endtask
  task automatic win(input logic [3:0] s, input logic [7:0] o, input logic [7:0] d, input int wr);
    seq(MAIN, 8'hB0, {2'b00, s, 2'b00, o, d}, 2 + wr, 1 - wr);
  endtask
  initial begin
    repeat (8) @(negedge ref_clk);
    chk(cfg, 32'h3324_0780);
    rstn = 1'b1;
    repeat (4) @(negedge ref_clk);
    for (int i = 1; i < 6; i++) begin
      win(4'h0, 8'(i), 8'h00, 0);
      chk(rb[0], rst_pg[47-8*i -: 8]);
    end
    $display("reset test done");
    foreach (rows[r]) begin
      win(rows[r][27:24], rows[r][23:16], rows[r][15:8], 1);
      win(rows[r][27:24], rows[r][23:16], 8'h00, 0);
      chk(rb[0], rows[r][7:0]);
    end
    win(4'h2, 8'h10, 8'h00, 0);
    chk(rb[0], 8'hC3);
    chk(cfg, 32'hE55E_1234);
    for (int b = 0; b < 4; b++) begin
      win(4'h0, 8'h02, 8'(b * 20 + 3), 1);
      chk({fixed_color_select, bar_count, block_size}, 7'(b * 20 + 3));
    end
    win(4'h0, 8'h01, 8'h00, 1);
    chk(pattern_run, 1'b0);
    $display("window test done");
    seq(MAIN, 8'hB0, {8'h02, 8'h06, 8'hD1}, 3, 0);
    seq(MAIN, 8'hB2, {8'hD2, 16'h0000}, 1, 0);
    seq(MAIN, 8'hB1, 24'h0, 0, 1);
    chk(rb[0], 8'h08);
    seq(MAIN, 8'hB0, {8'h02, 8'h06, 8'h00}, 2, 1);
    chk(rb[0], 8'hD1);
    seq(MAIN, 8'hB2, 24'h0, 0, 1);
    chk(rb[0], 8'hD2);
    $display("increment test done");
    seq(7'h21, 8'h10, 24'h0, 0, 0);
    chk(ack, 1'b1);
    seq(MAIN, 8'h12, {8'h76, 16'h0000}, 1, 0);
    chk(seen, {2'b01, 8'h12, 8'h76});
    seq(MAIN, 8'h4C, {8'h02, 16'h0000}, 1, 0);
    seq(MAIN, 8'h12, {8'h77, 16'h0000}, 1, 0);
    chk(seen, {2'b10, 8'h12, 8'h77});
    seq(MAIN, 8'hF8, {8'h43, 8'h45, 8'h00}, 2, 0);
    seq(MAIN, 8'hF8, 24'h0, 0, 2);
    chk({rb[0], rb[1]}, 16'h4244);
    seq(7'h21, 8'h10, {8'h9C, 16'h0000}, 1, 0);
    chk(seen, {2'b01, 8'h10, 8'h9C});
    seq(7'h22, 8'h11, {8'h3D, 16'h0000}, 1, 0);
    chk(seen, {2'b10, 8'h11, 8'h3D});
    seq(7'h21, 8'h10, 24'h0, 0, 1);
    chk(rb[0], 8'h4A);
    seq(MAIN, 8'hF4, {16'h0000, 8'h00}, 2, 0);
    seq(MAIN, 8'hFA, {16'hFFFF, 8'h00}, 2, 0);
    seq(7'h22, 8'hF4, 24'h0, 0, 2);
    chk({rb[0], rb[1]}, {ID5, ID6});
    seq(7'h21, 8'hFA, 24'h0, 0, 2);
    chk({rb[0], rb[1]}, 16'h0000);
    seq(MAIN, 8'hF8, {8'h00, 16'h0000}, 1, 0);
    seq(7'h21, 8'h10, 24'h0, 0, 0);
    chk(ack, 1'b1);
    $display("alias test done");
    rstn = 1'b0;
    @(negedge ref_clk);
    chk(cfg, 32'h3324_0780);
    rstn = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk(cfg, 32'h3324_0780);
    $display("second reset test done");
    wrap_up();
  end
endmodule // tb
`default_nettype wire
